/* File: hw/serial_port_pkg.sv */
// constants and carrier types shared by the synchronous client port
package serial_port_pkg;

    // =========================================================
    // register map (byte addresses on the AXI4-Lite bus)
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_TX_DATA = 4'h8;
    localparam logic [3:0] OFS_RX_DATA = 4'hC;

    // =========================================================
    // control register layout, low bit first
    localparam int CB_PORT_ENABLE = 0;
    localparam int CB_SYNC_MODE = 1;
    localparam int CB_CLOCK_SOURCE_SEL = 2;
    localparam int CB_TX_ENABLE = 3;
    localparam int CB_SINGLE_RX_EN = 4;
    localparam int CB_CONTINUOUS_RX_EN = 5;
    localparam int CB_TX_NINE_BIT_SEL = 6;
    localparam int CB_RX_NINE_BIT_SEL = 7;
    localparam int CB_TX_NINTH_BIT = 8;
    localparam int CB_TX_IRQ_EN = 9;
    localparam int CB_RX_IRQ_EN = 10;
    localparam int CB_PERIPHERAL_IRQ_EN = 11;
    localparam int CB_GLOBAL_IRQ_EN = 12;
    localparam logic [15:0] CTRL_WMASK = 16'h1FFF;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // field order matches the CB_ positions above
    typedef struct packed {
        logic [2:0] reserved;
        logic global_irq_en;
        logic peripheral_irq_en;
        logic rx_irq_en;
        logic tx_irq_en;
        logic tx_ninth_bit;
        logic rx_nine_bit_sel;
        logic tx_nine_bit_sel;
        logic continuous_rx_en;
        logic single_rx_en;
        logic tx_enable;
        logic clock_source_sel;
        logic sync_mode;
        logic port_enable;
    } ctrl_t;

    // =========================================================
    // status register layout (read only)
    localparam int SB_TX_EMPTY = 0;
    localparam int SB_RX_FULL = 1;
    localparam int SB_OVERRUN = 2;
    localparam int SB_RX_NINTH = 3;
    localparam int SB_TSR_EMPTY = 4;
    localparam int SB_CLIENT = 5;
    localparam int SB_TX_DIR = 6;

    // =========================================================
    // word format and buffering
    localparam int DATA_BITS = 8;
    localparam int WORD_BITS = 9;
    localparam int RX_FIFO_DEPTH = 2;
    localparam logic [3:0] LEN_EIGHT = 4'h8;
    localparam logic [3:0] LEN_NINE = 4'h9;

    // =========================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {TX_IDLE, TX_SHIFT} tx_state_t;

endpackage

/* File: hw/sync_edge.sv */
// two-stage synchroniser with edge detection for one pin
`timescale 1ns/1ns
module sync_edge (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } state_t;

    state_t cur;
    state_t next;

    // =========================================================
    // meta is read only by stable, never by the edge logic
    always_comb begin
        next = cur;
        next.meta = async_in;
        next.stable = cur.meta;
        next.last = cur.stable;
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    // edges come from the settled stages only
    assign level = cur.stable;
    assign rise = cur.stable & ~cur.last;
    assign fall = ~cur.stable & cur.last;
endmodule

/* File: hw/rx_fifo.sv */
// small receive fifo holding whole received characters
`timescale 1ns/1ns
module rx_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    output logic full,
    output logic empty,
    output logic [WIDTH-1:0] head
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    if (DEPTH < 2 || WIDTH < 1) begin : bad_shape
        $error("rx_fifo needs at least two entries");
    end

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] rd_ptr;
        logic [PW-1:0] wr_ptr;
        logic [CW-1:0] count;
    } state_t;

    state_t cur;
    state_t next;

    // pointer step with wrap for depths that are not powers of two
    function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
        step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
    endfunction

    // =========================================================
    // pushes into a full fifo are refused; the owner flags overrun
    always_comb begin
        logic do_push;
        logic do_pop;
        do_push = push & ~full;
        do_pop = pop & ~empty;
        next = cur;
        if (do_push) begin
            next.mem[cur.wr_ptr] = push_data;
            next.wr_ptr = step(cur.wr_ptr);
        end
        if (do_pop) begin
            next.rd_ptr = step(cur.rd_ptr);
        end
        if (do_push && !do_pop) begin
            next.count = CW'(cur.count + 1'b1);
        end else if (do_pop && !do_push) begin
            next.count = CW'(cur.count - 1'b1);
        end
        if (flush) begin
            next.rd_ptr = '0;
            next.wr_ptr = '0;
            next.count = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
        end else begin
            cur <= next;
        end
    end

    assign full = (cur.count == CW'(DEPTH));
    assign empty = (cur.count == '0);
    assign head = cur.mem[cur.rd_ptr];
endmodule

/* File: hw/sync_serial_client_port.sv */
// synchronous serial client port with an AXI4-Lite register slave
//
// The implementer's own choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
module sync_serial_client_port (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [serial_port_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [serial_port_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic sleep_active,
    input wire logic clock_pin_in,
    input wire logic data_pin_in,
    output logic data_pin_out,
    output logic data_pin_oe,
    output logic wake_req,
    output logic irq_req
);
    localparam int AW = serial_port_pkg::ADDR_W;
    localparam int WB = serial_port_pkg::WORD_BITS;

    typedef struct packed {
        serial_port_pkg::ctrl_t ctrl;
        logic aw_held;
        logic w_held;
        logic [AW-1:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [WB-1:0] tx_hold;
        logic hold_full;
        serial_port_pkg::tx_state_t tx_state;
        logic [WB-1:0] tx_shift;
        logic [3:0] tx_len;
        logic [3:0] tx_cnt;
        logic [WB-1:0] rx_shift;
        logic [3:0] rx_cnt;
        logic overrun;
        logic tx_empty_flag;
        logic data_out;
        logic data_oe;
        logic wake;
        logic irq;
    } state_t;

    state_t cur;
    state_t next;

    // fifo and synchroniser wires
    logic ck_rise;
    logic ck_fall;
    logic dt_level;
    logic fifo_full;
    logic fifo_empty;
    logic [WB-1:0] fifo_head;
    logic fifo_push;
    logic fifo_pop;
    logic fifo_flush;
    logic [WB-1:0] fifo_data;

    // =========================================================
    // helpers

    // byte-lane merge of a bus write into an old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
            input logic [31:0] wd, input logic [3:0] strb);
        lane_merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                lane_merge[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
    endfunction

    // the offsets this slave answers
    function automatic logic is_mapped(input logic [AW-1:0] a);
        is_mapped = (a == serial_port_pkg::OFS_CTRL) ||
            (a == serial_port_pkg::OFS_STATUS) ||
            (a == serial_port_pkg::OFS_TX_DATA) ||
            (a == serial_port_pkg::OFS_RX_DATA);
    endfunction

    // word length from a nine-bit select
    function automatic logic [3:0] word_len(input logic nine);
        word_len = nine ? serial_port_pkg::LEN_NINE :
            serial_port_pkg::LEN_EIGHT;
    endfunction

    // =========================================================
    // pin synchronisers: clock edges found on core_clk
    sync_edge u_clock_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(clock_pin_in),
        .level(),
        .rise(ck_rise),
        .fall(ck_fall)
    );

    sync_edge u_data_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(data_pin_in),
        .level(dt_level),
        .rise(),
        .fall()
    );

    rx_fifo #(
        .WIDTH(WB),
        .DEPTH(serial_port_pkg::RX_FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .srst(srst),
        .flush(fifo_flush),
        .push(fifo_push),
        .push_data(fifo_data),
        .pop(fifo_pop),
        .full(fifo_full),
        .empty(fifo_empty),
        .head(fifo_head)
    );

    // =========================================================
    // mode decode
    logic client_mode;
    logic tx_dir;
    logic rx_run;
    logic [31:0] status_word;

    // only client mode is built, so nothing shifts in any other mode,
    // awake or asleep; sleep_active itself does not stop the link
    assign client_mode = cur.ctrl.port_enable & cur.ctrl.sync_mode &
        ~cur.ctrl.clock_source_sel;
    assign tx_dir = client_mode & ~cur.ctrl.single_rx_en &
        ~cur.ctrl.continuous_rx_en;
    // single receive starts no reception here, it only clears tx_dir; overrun stops reception
    assign rx_run = client_mode & cur.ctrl.continuous_rx_en &
        ~cur.overrun;

    always_comb begin
        status_word = '0;
        status_word[serial_port_pkg::SB_TX_EMPTY] = cur.tx_empty_flag;
        status_word[serial_port_pkg::SB_RX_FULL] = ~fifo_empty;
        status_word[serial_port_pkg::SB_OVERRUN] = cur.overrun;
        status_word[serial_port_pkg::SB_RX_NINTH] = fifo_head[WB-1];
        status_word[serial_port_pkg::SB_TSR_EMPTY] =
            (cur.tx_state == serial_port_pkg::TX_IDLE);
        status_word[serial_port_pkg::SB_CLIENT] = client_mode;
        status_word[serial_port_pkg::SB_TX_DIR] = tx_dir;
    end

    // =========================================================
    // next-state logic: bus slave, transmitter, receiver, requests
    always_comb begin
        logic wr_fire;
        logic tx_write;
        logic rd_pop;
        logic [WB-1:0] rx_new;
        logic [3:0] rx_len;
        logic rx_done;
        logic tx_finish;
        logic any_rx;
        logic tx_wake;
        logic rx_wake;
        next = cur;
        wr_fire = 1'b0;
        tx_write = 1'b0;
        rd_pop = 1'b0;
        rx_new = '0;
        rx_len = word_len(cur.ctrl.rx_nine_bit_sel);
        rx_done = 1'b0;
        tx_finish = 1'b0;
        any_rx = 1'b0;
        tx_wake = 1'b0;
        rx_wake = 1'b0;
        fifo_push = 1'b0;
        fifo_data = '0;

        // write address and data are taken in either order
        if (s_axi_awvalid && cur.awready) begin
            next.aw_held = 1'b1;
            next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && cur.wready) begin
            next.w_held = 1'b1;
            next.w_data = s_axi_wdata;
            next.w_strb = s_axi_wstrb;
        end
        if (cur.aw_held && cur.w_held && !cur.bvalid) begin
            wr_fire = 1'b1;
            next.aw_held = 1'b0;
            next.w_held = 1'b0;
            next.bvalid = 1'b1;
            next.bresp = is_mapped(cur.aw_addr) ?
                serial_port_pkg::RESP_OKAY : serial_port_pkg::RESP_SLVERR;
        end
        if (cur.bvalid && s_axi_bready) begin
            next.bvalid = 1'b0;
        end
        next.awready = ~next.aw_held & ~next.bvalid;
        next.wready = ~next.w_held & ~next.bvalid;

        if (wr_fire && cur.aw_addr == serial_port_pkg::OFS_CTRL) begin
            next.ctrl = serial_port_pkg::ctrl_t'(16'(lane_merge(
                32'(cur.ctrl), cur.w_data, cur.w_strb)
                & {16'h0000, serial_port_pkg::CTRL_WMASK}));
        end
        // a write into a still-full holding register is dropped
        if (wr_fire && cur.aw_addr == serial_port_pkg::OFS_TX_DATA &&
                cur.w_strb[0] && !cur.hold_full) begin
            tx_write = 1'b1;
        end

        // reads answer the cycle after the address is taken
        if (s_axi_arvalid && cur.arready) begin
            next.arready = 1'b0;
            next.rvalid = 1'b1;
            next.rresp = serial_port_pkg::RESP_OKAY;
            next.rdata = '0;
            case (s_axi_araddr)
                serial_port_pkg::OFS_CTRL: begin
                    next.rdata = 32'(cur.ctrl);
                end
                serial_port_pkg::OFS_STATUS: begin
                    next.rdata = status_word;
                end
                serial_port_pkg::OFS_TX_DATA: begin
                    next.rdata = 32'(cur.tx_hold);
                end
                serial_port_pkg::OFS_RX_DATA: begin
                    next.rdata = {24'h000000,
                        fifo_head[serial_port_pkg::DATA_BITS-1:0]};
                    rd_pop = 1'b1;
                end
                default: begin
                    next.rresp = serial_port_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (cur.rvalid && s_axi_rready) begin
            next.rvalid = 1'b0;
            next.arready = 1'b1;
        end

        // holding register load; ninth bit sits above the low eight
        if (tx_write) begin
            next.tx_hold = {cur.ctrl.tx_ninth_bit,
                cur.w_data[serial_port_pkg::DATA_BITS-1:0]};
            next.hold_full = 1'b1;
        end

        // transmit shifting; bits leave only on host clock edges
        case (cur.tx_state)
            serial_port_pkg::TX_IDLE: begin
                // an empty shift register takes the held word at once
                if (cur.hold_full && tx_dir && cur.ctrl.tx_enable) begin
                    next.tx_shift = cur.tx_hold;
                    next.tx_len = word_len(cur.ctrl.tx_nine_bit_sel);
                    next.tx_cnt = '0;
                    next.hold_full = 1'b0;
                    next.tx_state = serial_port_pkg::TX_SHIFT;
                end
            end
            serial_port_pkg::TX_SHIFT: begin
                if (tx_dir && ck_rise && cur.tx_cnt != cur.tx_len) begin
                    // leading edge presents the next bit, lsb first
                    next.data_out = cur.tx_shift[0];
                    next.tx_shift = {1'b0, cur.tx_shift[WB-1:1]};
                    next.tx_cnt = 4'(cur.tx_cnt + 1'b1);
                end
                if (tx_dir && ck_fall && cur.tx_cnt == cur.tx_len) begin
                    tx_finish = 1'b1;
                end
                if (tx_finish || !tx_dir) begin
                    next.tx_state = serial_port_pkg::TX_IDLE;
                end
            end
            default: begin
                next.tx_state = serial_port_pkg::TX_IDLE;
            end
        endcase
        // flag stays clear while a word waits behind the shifter
        next.tx_empty_flag = ~next.hold_full;
        next.data_oe = tx_dir & cur.ctrl.tx_enable;

        // receive: sample on the trailing edge, lsb first
        if (rx_run) begin
            if (ck_fall) begin
                rx_new = {dt_level, cur.rx_shift[WB-1:1]};
                next.rx_shift = rx_new;
                next.rx_cnt = 4'(cur.rx_cnt + 1'b1);
                if (4'(cur.rx_cnt + 1'b1) == rx_len) begin
                    rx_done = 1'b1;
                    next.rx_cnt = '0;
                end
            end
        end else begin
            // a partial word is dropped when reception stops
            next.rx_cnt = '0;
        end
        // finished words go to the fifo, asleep or not
        if (rx_done) begin
            fifo_data = cur.ctrl.rx_nine_bit_sel ? rx_new :
                {1'b0, rx_new[WB-1:1]};
            if (fifo_full) begin
                next.overrun = 1'b1;
            end else begin
                fifo_push = 1'b1;
            end
        end
        // set cannot meet this clear: reception is off while it holds
        if (!cur.ctrl.continuous_rx_en || !cur.ctrl.port_enable) begin
            next.overrun = 1'b0;
        end

        // disabling the port holds the link logic in reset
        if (!cur.ctrl.port_enable) begin
            next.hold_full = 1'b0;
            next.tx_state = serial_port_pkg::TX_IDLE;
            next.tx_cnt = '0;
            next.rx_cnt = '0;
            next.tx_empty_flag = 1'b1;
            next.data_oe = 1'b0;
            next.data_out = 1'b0;
            fifo_push = 1'b0;
        end

        // wake and interrupt requests from the live flags
        any_rx = ~fifo_empty | fifo_push;
        tx_wake = next.tx_empty_flag & cur.ctrl.tx_irq_en &
            cur.ctrl.peripheral_irq_en;
        rx_wake = any_rx & cur.ctrl.rx_irq_en;
        next.wake = tx_wake | rx_wake;
        next.irq = (tx_wake | rx_wake) & cur.ctrl.global_irq_en;

        fifo_pop = rd_pop;
    end

    assign fifo_flush = ~cur.ctrl.port_enable;

    // =========================================================
    // state register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cur <= '0;
            cur.ctrl <= serial_port_pkg::ctrl_t'(serial_port_pkg::CTRL_RESET);
            cur.awready <= 1'b1;
            cur.wready <= 1'b1;
            cur.arready <= 1'b1;
            cur.tx_state <= serial_port_pkg::TX_IDLE;
            cur.tx_empty_flag <= 1'b1;
        end else begin
            cur <= next;
        end
    end

    // every output straight from the state register
    assign s_axi_awready = cur.awready;
    assign s_axi_wready = cur.wready;
    assign s_axi_bvalid = cur.bvalid;
    assign s_axi_bresp = cur.bresp;
    assign s_axi_arready = cur.arready;
    assign s_axi_rvalid = cur.rvalid;
    assign s_axi_rdata = cur.rdata;
    assign s_axi_rresp = cur.rresp;
    assign data_pin_out = cur.data_out;
    assign data_pin_oe = cur.data_oe;
    assign wake_req = cur.wake;
    assign irq_req = cur.irq;
endmodule

/* File: dv/sync_serial_client_port_asserts.sv */
// concurrent checks on the client port's bus and pin behaviour
`timescale 1ns/1ns
module sync_serial_client_port_asserts (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic clock_pin_in,
    input wire logic data_pin_out,
    input wire logic data_pin_oe,
    input wire logic wake_req,
    input wire logic irq_req
);
    // =========================================================
    // one clock domain, reset disables everything
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    AST_RST_IDLE:
    assert property ($fell(srst) |-> !wake_req && !irq_req && !data_pin_oe
        && s_axi_awready && s_axi_arready) else $error("not idle after reset");
    AST_IRQ_GATE:
    assert property (irq_req |-> wake_req) else $error("irq without wake");
    AST_B_HOLD:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    AST_R_HOLD:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    AST_W_BLOCK:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    AST_R_LAT:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_LAT:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
    AST_TX_EDGE:
    assert property ($changed(data_pin_out) && $past(data_pin_oe)
        && data_pin_oe |-> $past(clock_pin_in, 3))
        else $error("data moved without a leading clock edge");
    AST_RV_CAUSE:
    assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
        else $error("read answer without request");
    // main scenarios seen
    cover property (wake_req && !irq_req);
    cover property (irq_req);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule

/* File: dv/serial_host_model.sv */
// behavioural serial host: shift clock, data out, samples the device
`timescale 1ns/1ns
module serial_host_model (
    input wire logic core_clk,
    input wire logic dev_dat,
    output logic clk_pin,
    output logic dat
);
    // clock stands low between frames
    initial begin
        clk_pin = 1'h0;
        dat = 1'h0;
    end
    // one word lsb first, 320 ns per bit; line inverted after the frame
    task automatic xfer(input logic [8:0] w, input int n,
            output logic [8:0] got);
        got = 9'h000;
        for (int i = 0; i < n; i++) begin
            @(posedge core_clk);
            clk_pin <= 1'h1;
            dat <= w[i];
            repeat (4) @(posedge core_clk);
            clk_pin <= 1'h0;
            repeat (3) @(posedge core_clk);
            got[i] = dev_dat;
        end
        dat <= ~dat;
    endtask
endmodule

/* File: dv/sync_serial_client_port_test.sv */
// self-checking bench for the synchronous client port
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    num_errors++; $display("unexpected %s exp %0h got %0h", n, e, s); end end
module sync_serial_client_port_test;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [8:0] word;
        logic wake;
        logic irq;
    } row_t;
    logic core_clk = 1'h0, srst = 1'h1, sleep_active = 1'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, data_pin_out, data_pin_oe, wake_req, irq_req;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp;
    logic clock_pin_in, host_dat, data_pin_in;
    logic [8:0] got;
    int num_errors = 0, comparisons = 0, cyc = 0;
    // receive rows: control word, host word, expected wake and irq
    row_t rows [3] = '{'{32'h0023, 9'h0A5, 1'h0, 1'h0},
        '{32'h04A3, 9'h15A, 1'h1, 1'h0}, '{32'h14B3, 9'h0C3, 1'h1, 1'h1}};
    // shared data pin: device wins while it drives
    assign data_pin_in = data_pin_oe ? data_pin_out : host_dat;
    always #20 core_clk = ~core_clk;
    sync_serial_client_port sync_serial_client_port_i (.*);
    serial_host_model serial_host_model_i (.core_clk(core_clk),
        .dev_dat(data_pin_in), .clk_pin(clock_pin_in), .dat(host_dat));
    // =========================================================
    // bus tasks, each channel held until its ready
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rd_resp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge core_clk);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= a;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd_val = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    task automatic complete_run;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard, far above the fewer than a thousand cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            num_errors++;
            complete_run();
        end
    end
    // =========================================================
    // main sequence
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'h0;
        rd(4'h0);
        `CHK("ctrl", 32'h0, rd_val)
        rd(4'h4);
        `CHK("tx_empty", 1'h1, rd_val[0])
        `CHK("oe", 1'h0, data_pin_oe)
        rd(4'h2);
        `CHK("resp", 2'h2, rd_resp)
        wr(4'h2, 32'h0);
        `CHK("bresp", 2'h2, rd_resp)
        sleep_active <= 1'h1;
        foreach (rows[k]) begin
            wr(4'h0, rows[k].ctrl);
            serial_host_model_i.xfer(rows[k].word, rows[k].ctrl[7] ? 9 : 8,
                got);
            rd(4'h4);
            `CHK("rx_full", 1'h1, rd_val[1])
            `CHK("ninth", rows[k].word[8], rd_val[3])
            `CHK("wake", rows[k].wake, wake_req)
            `CHK("irq", rows[k].irq, irq_req)
            rd(4'hC);
            `CHK("data", rows[k].word[7:0], rd_val[7:0])
            rd(4'h4);
            `CHK("rx_full", 1'h0, rd_val[1])
        end
        // two words back to back, second waits in the holding register
        wr(4'h0, 32'h0B4B);
        wr(4'h8, 32'h3C);
        wr(4'h8, 32'h96);
        rd(4'h4);
        `CHK("tx_empty", 1'h0, rd_val[0])
        `CHK("tx_dir", 1'h1, rd_val[6])
        `CHK("wake", 1'h0, wake_req)
        `CHK("oe", 1'h1, data_pin_oe)
        serial_host_model_i.xfer(9'h000, 9, got);
        `CHK("tx_word", 9'h13C, got)
        rd(4'h4);
        `CHK("tx_empty", 1'h1, rd_val[0])
        `CHK("wake", 1'h1, wake_req)
        `CHK("irq", 1'h0, irq_req)
        wr(4'h8, 32'h55);
        rd(4'h4);
        `CHK("tx_empty", 1'h0, rd_val[0])
        serial_host_model_i.xfer(9'h000, 9, got);
        `CHK("tx_word", 9'h196, got)
        // third word into a full fifo, then clear by receive disable
        wr(4'h0, 32'h0023);
        for (int i = 1; i < 4; i++) begin
            serial_host_model_i.xfer(9'(i * 17), 8, got);
        end
        rd(4'h4);
        `CHK("overrun", 1'h1, rd_val[2])
        rd(4'hC);
        `CHK("data", 8'h11, rd_val[7:0])
        rd(4'hC);
        `CHK("data", 8'h22, rd_val[7:0])
        wr(4'h0, 32'h0013);
        rd(4'h4);
        `CHK("overrun", 1'h0, rd_val[2])
        `CHK("tx_dir", 1'h0, rd_val[6])
        `CHK("client", 1'h1, rd_val[5])
        // host mode selected: nothing may shift in
        wr(4'h0, 32'h0027);
        serial_host_model_i.xfer(9'h0AA, 8, got);
        rd(4'h4);
        `CHK("rx_full", 1'h0, rd_val[1])
        complete_run();
    end
endmodule
bind sync_serial_client_port sync_serial_client_port_asserts
    sync_serial_client_port_asserts_i (.*);
